/* File: logic/srm_pkg.sv */
// Constants and reset routing tables for the signal routing matrix.
package srm_pkg;

    // ------------------------------------------------------------
    // Pin counts and source code layout
    // ------------------------------------------------------------
    localparam int A_PINS = 20;
    localparam int P_PINS = 14;
    localparam int CODE_LOW = 0;
    localparam int CODE_HIGH = 1;
    localparam int CODE_PIN1 = 2;
    localparam int EFFECT_MIN_CYCLES = 2;
    localparam int EFFECT_MAX_CYCLES = 3;

    // ------------------------------------------------------------
    // Group sizes: destinations, peripheral sources, code width
    // ------------------------------------------------------------
    localparam int CLK_D = 24;
    localparam int CLK_P = 9;
    localparam int CLK_W = 5;
    localparam int FS_D = 20;
    localparam int FS_P = 9;
    localparam int FS_W = 5;
    localparam int APIN_D = 20;
    localparam int APIN_P = 43;
    localparam int APIN_W = 7;
    localparam int AENA_D = 20;
    localparam int AENA_PX = 32;
    localparam int AENA_W = 6;
    localparam int AMSC_D = 16;
    localparam int AMSC_P = 10;
    localparam int AMSC_W = 5;
    localparam int AIRQ_N = 10;
    localparam int AMISC_N = 6;
    localparam int AMISC_IRQ_N = 4;
    localparam int PMSC_D = 39;
    localparam int PMSC_P = 3;
    localparam int PMSC_W = 5;
    localparam int PDEST_N = 21;
    localparam int PMISC_BASE = 21;
    localparam int PMISC_N = 9;
    localparam int PIRQ_BASE = 30;
    localparam int PIRQ_N = 9;
    localparam int PPIN_D = 14;
    localparam int PPIN_P = 21;
    localparam int PPIN_W = 6;
    localparam int PENA_D = 14;
    localparam int PENA_PX = 21;
    localparam int PENA_W = 6;

    // ------------------------------------------------------------
    // Default serial port and serial peripheral wiring
    // ------------------------------------------------------------
    localparam int SER_PORTS_DEF = 5;
    localparam int SER_PORT_SIGS = 4;
    localparam int SPI_DST_MOSI = 3;
    localparam int SPI_DST_MISO = 4;
    localparam int SPI_DST_CLK = 5;
    localparam int SPI_DST_SEL = 6;
    localparam int SPI_SRC_MOSI = 1;
    localparam int SPI_SRC_MISO = 2;
    localparam int SPI_SRC_CLK = 3;
    localparam int SPI_SRC_SEL = 4;
    localparam int SPI_EN_BASE = 3;

    function automatic logic [CLK_D*CLK_W-1:0] clk_default();
        logic [CLK_D*CLK_W-1:0] v;
        v = '0;
        for (int n = 0; n < SER_PORTS_DEF; n++) begin
            v[n*CLK_W +: CLK_W] = CLK_W'(CODE_PIN1 + SER_PORT_SIGS * n);
        end
        return v;
    endfunction

    function automatic logic [FS_D*FS_W-1:0] fs_default();
        logic [FS_D*FS_W-1:0] v;
        v = '0;
        for (int n = 0; n < SER_PORTS_DEF; n++) begin
            v[n*FS_W +: FS_W] = FS_W'(CODE_PIN1 + SER_PORT_SIGS * n + 1);
        end
        return v;
    endfunction

    function automatic logic [APIN_D*APIN_W-1:0] apin_default();
        logic [APIN_D*APIN_W-1:0] v;
        for (int i = 0; i < APIN_D; i++) begin
            v[i*APIN_W +: APIN_W] = APIN_W'(CODE_PIN1 + A_PINS + i);
        end
        return v;
    endfunction

    function automatic logic [AENA_D*AENA_W-1:0] aena_default();
        logic [AENA_D*AENA_W-1:0] v;
        for (int i = 0; i < AENA_D; i++) begin
            v[i*AENA_W +: AENA_W] = AENA_W'(CODE_PIN1 + A_PINS + i);
        end
        return v;
    endfunction

    function automatic logic [PMSC_D*PMSC_W-1:0] pmsc_default();
        logic [PMSC_D*PMSC_W-1:0] v;
        v = '0;
        v[SPI_DST_MOSI*PMSC_W +: PMSC_W] = PMSC_W'(CODE_PIN1 + 1);
        v[SPI_DST_MISO*PMSC_W +: PMSC_W] = PMSC_W'(CODE_PIN1 + 2);
        v[SPI_DST_CLK*PMSC_W +: PMSC_W] = PMSC_W'(CODE_PIN1);
        v[SPI_DST_SEL*PMSC_W +: PMSC_W] = PMSC_W'(CODE_PIN1 + 3);
        return v;
    endfunction

    function automatic logic [PPIN_D*PPIN_W-1:0] ppin_default();
        logic [PPIN_D*PPIN_W-1:0] v;
        v = '0;
        v[0 +: PPIN_W] = PPIN_W'(CODE_PIN1 + P_PINS + SPI_SRC_CLK);
        v[PPIN_W +: PPIN_W] = PPIN_W'(CODE_PIN1 + P_PINS + SPI_SRC_MOSI);
        v[2*PPIN_W +: PPIN_W] = PPIN_W'(CODE_PIN1 + P_PINS + SPI_SRC_MISO);
        v[3*PPIN_W +: PPIN_W] = PPIN_W'(CODE_PIN1 + P_PINS + SPI_SRC_SEL);
        return v;
    endfunction

    function automatic logic [PENA_D*PENA_W-1:0] pena_default();
        logic [PENA_D*PENA_W-1:0] v;
        v = '0;
        v[0 +: PENA_W] = PENA_W'(CODE_PIN1 + P_PINS + SPI_EN_BASE + 2);
        v[PENA_W +: PENA_W] = PENA_W'(CODE_PIN1 + P_PINS + SPI_EN_BASE);
        v[2*PENA_W +: PENA_W] = PENA_W'(CODE_PIN1 + P_PINS + SPI_EN_BASE + 1);
        v[3*PENA_W +: PENA_W] = PENA_W'(CODE_PIN1 + P_PINS + SPI_EN_BASE + 3);
        return v;
    endfunction

endpackage

/* File: logic/srm_routing_matrix.sv */
// Routing crossbar for the audio-side and peripheral-side routers.
//
// Functional notes
// - One source may feed many destinations.
// - Each destination takes exactly one source.
// - Destinations select only same-side sources.
// - Every group has pin buffer output codes.
// - Audio clock group destinations and sources.
// - Audio frame sync group routing.
// - Audio pin group drives pin buffer inputs.
// - Audio enable group sets pin direction.
// - Audio misc group drives interrupts, misc buffers.
// - Audio misc outputs feed interrupts, enable group.
// - Peripheral misc outputs feed interrupts, enable group.
// - Peripheral pin group drives pin buffers.
// - Peripheral enable group drives pin enables.
// - Serial ports bidirectional on pins after reset.
// - Audio undefaulted inputs and enables low.
// - Peripheral undefaulted inputs and enables low.
// - Serial peripheral default; boot sets enables 1-2.
// - Pin buffers 20-19 optionally invert.
// - Audio misc buffers 5-4 optionally invert.
// - Invertible misc buffers bypass interrupt logic.
// - Each destination has its own code field.
// - New routing takes effect in 2-3 cycles.
// - Enabled pin buffer output equals its input.
`timescale 1ns/1ps

module srm_route_group #(
    parameter int DESTS = 1,
    parameter int CODE_W = 1,
    parameter int SRCS = 2,
    parameter logic [DESTS*CODE_W-1:0] DEFAULT = '0
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_write,
    input wire logic [DESTS*CODE_W-1:0] i_code,
    input wire logic [DESTS-1:0] i_invert,
    input wire logic [SRCS-1:0] i_src,
    output logic [DESTS-1:0] o_dest
);
    logic [DESTS*CODE_W-1:0] cfg;
    logic [DESTS*CODE_W-1:0] active;
    logic [DESTS-1:0] next_dest;

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            cfg <= DEFAULT;
        end else if (i_write) begin
            cfg <= i_code;
        end
    end

    // ------------------------------------------------------------
    // Staging
    // ------------------------------------------------------------
    // The second stage keeps a half-written field set from ever
    // reaching the mux, at the cost of one cycle of latency.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            active <= DEFAULT;
        end else begin
            active <= cfg;
        end
    end

    genvar d;
    generate
        for (d = 0; d < DESTS; d++) begin : g_dest
            logic [CODE_W-1:0] code;
            assign code = active[d*CODE_W +: CODE_W];
            // Codes past the last source read as constant low.
            assign next_dest[d] = (int'(code) < SRCS) ?
                (i_src[code] ^ i_invert[d]) : 1'b0;
        end
    endgenerate

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_dest <= '0;
        end else begin
            o_dest <= next_dest;
        end
    end
endmodule

module srm_routing_matrix (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_cfg_write,
    input wire logic [119:0] i_clock_group_route_reg,
    input wire logic [99:0] i_fs_route,
    input wire logic [139:0] i_apin_route,
    input wire logic [119:0] i_aena_route,
    input wire logic [79:0] i_amsc_route,
    input wire logic [194:0] i_pmsc_route,
    input wire logic [83:0] i_ppin_route,
    input wire logic [83:0] i_pena_route,
    input wire logic [1:0] i_pin_invert_bit,
    input wire logic [1:0] i_misc_invert_bit,
    input wire logic i_spi_boot,
    input wire logic i_spi_boot_master,
    input wire logic [8:0] i_clk_src,
    input wire logic [8:0] i_fs_src,
    input wire logic [42:0] i_apin_src,
    input wire logic [31:0] i_aena_src,
    input wire logic [9:0] i_amsc_src,
    input wire logic [2:0] i_pmsc_src,
    input wire logic [20:0] i_ppin_src,
    input wire logic [20:0] i_pena_src,
    input wire logic [19:0] i_audio_pad,
    output logic [19:0] o_audio_pad,
    output logic [19:0] o_audio_pad_oe_n,
    input wire logic [13:0] i_periph_pad,
    output logic [13:0] o_periph_pad,
    output logic [13:0] o_periph_pad_oe_n,
    output logic [23:0] o_clk_dest,
    output logic [19:0] o_fs_dest,
    output logic [9:0] o_audio_irq,
    output logic [3:0] o_audio_misc_irq,
    output logic [20:0] o_periph_dest,
    output logic [8:0] o_periph_misc_irq,
    output logic [8:0] o_periph_irq
);
    logic [19:0] a_pin_in;
    logic [19:0] a_pin_en;
    logic [19:0] a_pb_out;
    logic [15:0] a_msc;
    logic [13:0] p_pin_in;
    logic [13:0] p_pin_en;
    logic [13:0] p_en_eff;
    logic [13:0] p_pb_out;
    logic [38:0] p_msc;
    logic [19:0] a_pin_inv;
    logic [15:0] a_msc_inv;

    // ------------------------------------------------------------
    // Pin buffers
    // ------------------------------------------------------------
    // An enabled buffer reads back its own drive, so an output pin
    // never loops the pad level into the matrix.
    assign a_pb_out = (a_pin_en & a_pin_in) | (~a_pin_en & i_audio_pad);
    assign p_pb_out = (p_en_eff & p_pin_in) | (~p_en_eff & i_periph_pad);
    assign o_audio_pad = a_pin_in;
    assign o_audio_pad_oe_n = ~a_pin_en;
    assign o_periph_pad = p_pin_in;
    assign o_periph_pad_oe_n = ~p_en_eff;

    // Boot over the serial peripheral overrides enables 1 and 2:
    // only a master drives its clock and data out pins.
    assign p_en_eff = i_spi_boot ?
        {p_pin_en[13:2], {2{i_spi_boot_master}}} : p_pin_en;

    // Only buffers 20-19 and misc 5-4 can invert. Routing either
    // back to itself would oscillate, so software must not.
    assign a_pin_inv = {i_pin_invert_bit, 18'h00000};
    assign a_msc_inv = {i_misc_invert_bit, 14'h0000};

    // ------------------------------------------------------------
    // Audio-side router
    // ------------------------------------------------------------
    srm_route_group #(
        .DESTS(srm_pkg::CLK_D),
        .CODE_W(srm_pkg::CLK_W),
        .SRCS(srm_pkg::CODE_PIN1 + srm_pkg::A_PINS + srm_pkg::CLK_P),
        .DEFAULT(srm_pkg::clk_default())
    ) u_clk (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_write(i_cfg_write),
        .i_code(i_clock_group_route_reg),
        .i_invert(24'h000000),
        .i_src({i_clk_src, a_pb_out, 1'b1, 1'b0}),
        .o_dest(o_clk_dest)
    );

    srm_route_group #(
        .DESTS(srm_pkg::FS_D),
        .CODE_W(srm_pkg::FS_W),
        .SRCS(srm_pkg::CODE_PIN1 + srm_pkg::A_PINS + srm_pkg::FS_P),
        .DEFAULT(srm_pkg::fs_default())
    ) u_fs (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_write(i_cfg_write),
        .i_code(i_fs_route),
        .i_invert(20'h00000),
        .i_src({i_fs_src, a_pb_out, 1'b1, 1'b0}),
        .o_dest(o_fs_dest)
    );

    srm_route_group #(
        .DESTS(srm_pkg::APIN_D),
        .CODE_W(srm_pkg::APIN_W),
        .SRCS(srm_pkg::CODE_PIN1 + srm_pkg::A_PINS + srm_pkg::APIN_P),
        .DEFAULT(srm_pkg::apin_default())
    ) u_apin (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_write(i_cfg_write),
        .i_code(i_apin_route),
        .i_invert(a_pin_inv),
        .i_src({i_apin_src, a_pb_out, 1'b1, 1'b0}),
        .o_dest(a_pin_in)
    );

    srm_route_group #(
        .DESTS(srm_pkg::AENA_D),
        .CODE_W(srm_pkg::AENA_W),
        .SRCS(srm_pkg::CODE_PIN1 + srm_pkg::A_PINS + srm_pkg::AENA_PX
            + srm_pkg::AMISC_N),
        .DEFAULT(srm_pkg::aena_default())
    ) u_aena (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_write(i_cfg_write),
        .i_code(i_aena_route),
        .i_invert(20'h00000),
        .i_src({a_msc[15:10], i_aena_src, a_pb_out, 1'b1, 1'b0}),
        .o_dest(a_pin_en)
    );

    srm_route_group #(
        .DESTS(srm_pkg::AMSC_D),
        .CODE_W(srm_pkg::AMSC_W),
        .SRCS(srm_pkg::CODE_PIN1 + srm_pkg::A_PINS + srm_pkg::AMSC_P),
        .DEFAULT('0)
    ) u_amsc (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_write(i_cfg_write),
        .i_code(i_amsc_route),
        .i_invert(a_msc_inv),
        .i_src({i_amsc_src, a_pb_out, 1'b1, 1'b0}),
        .o_dest(a_msc)
    );

    assign o_audio_irq = a_msc[9:0];
    // Misc buffers 5-4 stay out of the interrupt path.
    assign o_audio_misc_irq = a_msc[13:10];

    // ------------------------------------------------------------
    // Peripheral-side router
    // ------------------------------------------------------------
    srm_route_group #(
        .DESTS(srm_pkg::PMSC_D),
        .CODE_W(srm_pkg::PMSC_W),
        .SRCS(srm_pkg::CODE_PIN1 + srm_pkg::P_PINS + srm_pkg::PMSC_P),
        .DEFAULT(srm_pkg::pmsc_default())
    ) u_pmsc (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_write(i_cfg_write),
        .i_code(i_pmsc_route),
        .i_invert(39'h0000000000),
        .i_src({i_pmsc_src, p_pb_out, 1'b1, 1'b0}),
        .o_dest(p_msc)
    );

    assign o_periph_dest = p_msc[20:0];
    assign o_periph_misc_irq = p_msc[29:21];
    assign o_periph_irq = p_msc[38:30];

    srm_route_group #(
        .DESTS(srm_pkg::PPIN_D),
        .CODE_W(srm_pkg::PPIN_W),
        .SRCS(srm_pkg::CODE_PIN1 + srm_pkg::P_PINS + srm_pkg::PPIN_P),
        .DEFAULT(srm_pkg::ppin_default())
    ) u_ppin (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_write(i_cfg_write),
        .i_code(i_ppin_route),
        .i_invert(14'h0000),
        .i_src({i_ppin_src, p_pb_out, 1'b1, 1'b0}),
        .o_dest(p_pin_in)
    );

    srm_route_group #(
        .DESTS(srm_pkg::PENA_D),
        .CODE_W(srm_pkg::PENA_W),
        .SRCS(srm_pkg::CODE_PIN1 + srm_pkg::P_PINS + srm_pkg::PENA_PX
            + srm_pkg::PMISC_N),
        .DEFAULT(srm_pkg::pena_default())
    ) u_pena (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_write(i_cfg_write),
        .i_code(i_pena_route),
        .i_invert(14'h0000),
        .i_src({p_msc[29:21], i_pena_src, p_pb_out, 1'b1, 1'b0}),
        .o_dest(p_pin_en)
    );
endmodule

/* File: sim/srm_pad_model.sv */
// Behavioural pads and board drivers on the far side of the router.
`timescale 1ns/1ps

module srm_pad_model #(
    parameter int N = 20
) (
    input wire logic i_clock,
    input wire logic [N-1:0] i_drive,
    input wire logic [N-1:0] i_oe_n,
    input wire logic [N-1:0] i_ext_en,
    input wire logic [N-1:0] i_ext_val,
    output logic [N-1:0] o_level
);
    // An undriven pin has no pull, so it toggles every cycle and a
    // stale level can never pass for a routed one.
    logic [N-1:0] float_q = '0;

    always_ff @(posedge i_clock) begin
        float_q <= ~float_q;
    end

    // ------------------------------------------------------------
    // Pin level seen by the router
    // ------------------------------------------------------------
    assign o_level = (~i_oe_n & i_drive)
        | (i_oe_n & i_ext_en & i_ext_val) | (i_oe_n & ~i_ext_en & float_q);
endmodule

/* File: sim/srm_routing_matrix_sva.sv */
// Port assertions for the signal routing matrix.
`timescale 1ns/1ps

module srm_routing_matrix_sva (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_cfg_write,
    input wire logic [119:0] i_clock_group_route_reg,
    input wire logic [99:0] i_fs_route,
    input wire logic [139:0] i_apin_route,
    input wire logic [119:0] i_aena_route,
    input wire logic [79:0] i_amsc_route,
    input wire logic [194:0] i_pmsc_route,
    input wire logic [1:0] i_pin_invert_bit,
    input wire logic i_spi_boot,
    input wire logic i_spi_boot_master,
    input wire logic [8:0] i_clk_src,
    input wire logic [9:0] i_amsc_src,
    input wire logic [2:0] i_pmsc_src,
    input wire logic [19:0] o_audio_pad,
    input wire logic [19:0] o_audio_pad_oe_n,
    input wire logic [13:0] o_periph_pad_oe_n,
    input wire logic [23:0] o_clk_dest,
    input wire logic [19:0] o_fs_dest,
    input wire logic [9:0] o_audio_irq,
    input wire logic [20:0] o_periph_dest
);
    // Until the first write the routes are the reset defaults, not
    // what the route ports show, so port-based checks wait for it.
    logic wrote;

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            wrote <= 1'b0;
        end else if (i_cfg_write) begin
            wrote <= 1'b1;
        end
    end

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_reset_outputs_clear: assert property ($fell(i_rst) |->
        o_clk_dest == '0 && o_fs_dest == '0 && o_audio_pad_oe_n == '1)
        else $error("outputs not cleared by reset");
    a_cfg_effect_time: assert property (
        i_cfg_write && i_clock_group_route_reg == {24{5'h01}}
        ##1 !i_cfg_write [*2] |=> o_clk_dest == '1)
        else $error("route change late");
    a_low_code_low: assert property (
        i_cfg_write && i_fs_route == '0 ##1 !i_cfg_write [*2]
        |=> o_fs_dest == '0) else $error("low code not low");
    a_unused_code_low: assert property (
        i_cfg_write && i_aena_route == {20{6'h3F}} ##1 !i_cfg_write [*2]
        |=> o_audio_pad_oe_n == '1) else $error("unused code not low");
    a_boot_master_en: assert property (
        (i_spi_boot && i_spi_boot_master) [*3]
        |-> o_periph_pad_oe_n[1:0] == 2'b00)
        else $error("master boot enables wrong");
    a_boot_slave_en: assert property (
        (i_spi_boot && !i_spi_boot_master) [*3]
        |-> o_periph_pad_oe_n[1:0] == 2'b11)
        else $error("slave boot enables wrong");
    a_fanout_one_src: assert property (
        (wrote && i_clock_group_route_reg == {24{5'h16}} && !i_cfg_write)
        [*4] |-> o_clk_dest == {24{$past(i_clk_src[0])}})
        else $error("fan-out copy wrong");
    a_pin_invert: assert property (
        (wrote && i_apin_route[139:133] == 7'h01 && !i_cfg_write
        && $stable(i_pin_invert_bit)) [*4]
        |-> o_audio_pad[19] == !i_pin_invert_bit[1])
        else $error("pin inversion wrong");
    a_irq_follow: assert property (
        (wrote && i_amsc_route[4:0] == 5'h16 && !i_cfg_write) [*4]
        |-> o_audio_irq[0] == $past(i_amsc_src[0]))
        else $error("interrupt source wrong");
    a_periph_follow: assert property (
        (wrote && i_pmsc_route[4:0] == 5'h10 && !i_cfg_write) [*4]
        |-> o_periph_dest[0] == $past(i_pmsc_src[0]))
        else $error("timer input source wrong");

    c_cfg: cover property (i_cfg_write);
    c_boot: cover property (i_spi_boot && i_spi_boot_master);
    c_inv: cover property (i_pin_invert_bit[1] && !o_audio_pad[19]);
endmodule

bind srm_routing_matrix srm_routing_matrix_sva u_sva (.i_clock, .i_rst,
    .i_cfg_write, .i_clock_group_route_reg, .i_fs_route, .i_apin_route,
    .i_aena_route, .i_amsc_route, .i_pmsc_route, .i_pin_invert_bit,
    .i_spi_boot, .i_spi_boot_master, .i_clk_src, .i_amsc_src, .i_pmsc_src,
    .o_audio_pad, .o_audio_pad_oe_n, .o_periph_pad_oe_n, .o_clk_dest,
    .o_fs_dest, .o_audio_irq, .o_periph_dest);

/* File: sim/test_srm_routing_matrix.sv */
// Self-checking bench for the signal routing matrix.
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module test_srm_routing_matrix;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic i_cfg_write = 1'b0;
    logic [119:0] i_clock_group_route_reg = '0;
    logic [99:0] i_fs_route = '0;
    logic [139:0] i_apin_route = '0;
    logic [119:0] i_aena_route = '0;
    logic [79:0] i_amsc_route = '0;
    logic [194:0] i_pmsc_route = '0;
    logic [83:0] i_ppin_route = '0;
    logic [83:0] i_pena_route = '0;
    logic [1:0] i_pin_invert_bit = '0;
    logic [1:0] i_misc_invert_bit = '0;
    logic i_spi_boot = 1'b0;
    logic i_spi_boot_master = 1'b0;
    logic [8:0] i_clk_src = '0;
    logic [8:0] i_fs_src = '0;
    logic [42:0] i_apin_src = '0;
    logic [31:0] i_aena_src = '0;
    logic [9:0] i_amsc_src = '0;
    logic [2:0] i_pmsc_src = '0;
    logic [20:0] i_ppin_src = '0;
    logic [20:0] i_pena_src = '0;
    logic [19:0] ext_en = '0;
    logic [19:0] ext_val = '0;
    logic [19:0] i_audio_pad, o_audio_pad, o_audio_pad_oe_n, o_fs_dest;
    logic [13:0] i_periph_pad, o_periph_pad, o_periph_pad_oe_n;
    logic [23:0] o_clk_dest;
    logic [9:0] o_audio_irq;
    logic [3:0] o_audio_misc_irq;
    logic [20:0] o_periph_dest;
    logic [8:0] o_periph_misc_irq, o_periph_irq;
    int mismatches = 0;
    int checked = 0;

    srm_routing_matrix DUT (.i_clock, .i_rst, .i_cfg_write,
        .i_clock_group_route_reg, .i_fs_route, .i_apin_route, .i_aena_route,
        .i_amsc_route, .i_pmsc_route, .i_ppin_route, .i_pena_route,
        .i_pin_invert_bit, .i_misc_invert_bit, .i_spi_boot,
        .i_spi_boot_master, .i_clk_src, .i_fs_src, .i_apin_src, .i_aena_src,
        .i_amsc_src, .i_pmsc_src, .i_ppin_src, .i_pena_src, .i_audio_pad,
        .o_audio_pad, .o_audio_pad_oe_n, .i_periph_pad, .o_periph_pad,
        .o_periph_pad_oe_n, .o_clk_dest, .o_fs_dest, .o_audio_irq,
        .o_audio_misc_irq, .o_periph_dest, .o_periph_misc_irq, .o_periph_irq);
    srm_pad_model #(.N(20)) u_apad (.i_clock, .i_drive(o_audio_pad),
        .i_oe_n(o_audio_pad_oe_n), .i_ext_en(ext_en), .i_ext_val(ext_val),
        .o_level(i_audio_pad));
    srm_pad_model #(.N(14)) u_ppad (.i_clock, .i_drive(o_periph_pad),
        .i_oe_n(o_periph_pad_oe_n), .i_ext_en(14'h0000),
        .i_ext_val(14'h0000), .o_level(i_periph_pad));

    initial begin
        forever #50 i_clock = ~i_clock;
    end

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask

    task automatic cfg();
        @(posedge i_clock);
        i_cfg_write <= 1'b1;
        @(posedge i_clock);
        i_cfg_write <= 1'b0;
        cyc(5);
    endtask

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask

    task automatic final_report();
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #5000000;
        mismatches++;
        final_report();
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge i_clock);
        i_rst <= 1'b0;
        i_aena_src <= '1;
        i_apin_src <= 43'h5A3C9;
        i_pena_src <= '1;
        i_ppin_src <= 21'h00000A;
        cyc(6);
        `CHK(o_audio_pad, 20'h5A3C9)
        `CHK(o_clk_dest, 24'h000015)
        `CHK(o_fs_dest, 20'h0000C)
        `CHK(o_periph_pad_oe_n, 14'h3FF0)
        `CHK(o_periph_dest, 21'h000028)
        `CHK(o_audio_irq, 10'h000)
        @(posedge i_clock);
        i_aena_src <= '0;
        ext_en <= '1;
        ext_val <= 20'h00011;
        cyc(4);
        `CHK(o_audio_pad_oe_n, 20'hFFFFF)
        `CHK(o_clk_dest, 24'h000003)
        done("defaults");
        @(posedge i_clock);
        i_clock_group_route_reg <= {24{5'h01}};
        i_fs_route <= '0;
        cfg();
        `CHK(o_clk_dest, 24'hFFFFFF)
        @(posedge i_clock);
        i_clock_group_route_reg <= {24{5'h16}};
        i_clk_src <= 9'h001;
        cfg();
        `CHK(o_clk_dest, 24'hFFFFFF)
        @(posedge i_clock);
        i_clk_src <= 9'h1FE;
        cyc(3);
        `CHK(o_clk_dest, 24'h000000)
        @(posedge i_clock);
        for (int d = 0; d < 24; d++) begin
            i_clock_group_route_reg[d*5 +: 5] <= (d % 3 == 0) ? 5'h01 : 5'h1F;
        end
        i_clock_group_route_reg[9:5] <= 5'h02;
        cfg();
        `CHK(o_clk_dest, 24'h24924B)
        done("clock group");
        @(posedge i_clock);
        i_apin_route <= {20{7'h01}};
        i_aena_route <= {20{6'h3F}};
        cfg();
        `CHK(o_audio_pad, 20'hFFFFF)
        `CHK(o_audio_pad_oe_n, 20'hFFFFF)
        @(posedge i_clock);
        i_pin_invert_bit <= 2'b11;
        i_aena_route <= {20{6'h01}};
        cfg();
        `CHK(o_audio_pad, 20'h3FFFF)
        `CHK(o_audio_pad_oe_n, 20'h00000)
        @(posedge i_clock);
        i_pin_invert_bit <= 2'b01;
        cyc(4);
        `CHK(o_audio_pad, 20'hBFFFF)
        done("pins");
        @(posedge i_clock);
        i_amsc_route <= {16{5'h16}};
        i_amsc_src <= 10'h001;
        i_misc_invert_bit <= 2'b01;
        i_aena_route <= {{18{6'h01}}, 6'h38, 6'h3A};
        cfg();
        `CHK(o_audio_irq, 10'h3FF)
        `CHK(o_audio_misc_irq, 4'hF)
        `CHK(o_audio_pad_oe_n, 20'h00001)
        @(posedge i_clock);
        i_amsc_src <= 10'h000;
        cyc(4);
        `CHK(o_audio_irq, 10'h000)
        `CHK(o_audio_pad_oe_n, 20'h00002)
        done("misc");
        @(posedge i_clock);
        i_pmsc_route <= {39{5'h10}};
        i_pmsc_src <= 3'h1;
        i_ppin_route <= {14{6'h01}};
        i_pena_route <= {{13{6'h00}}, 6'h25};
        cfg();
        `CHK(o_periph_dest, 21'h1FFFFF)
        `CHK(o_periph_misc_irq, 9'h1FF)
        `CHK(o_periph_irq, 9'h1FF)
        `CHK(o_periph_pad, 14'h3FFF)
        `CHK(o_periph_pad_oe_n, 14'h3FFE)
        @(posedge i_clock);
        i_pmsc_src <= 3'h0;
        cyc(4);
        `CHK(o_periph_dest, 21'h000000)
        `CHK(o_periph_pad_oe_n, 14'h3FFF)
        @(posedge i_clock);
        i_spi_boot <= 1'b1;
        i_spi_boot_master <= 1'b1;
        cyc(4);
        `CHK(o_periph_pad_oe_n[1:0], 2'b00)
        @(posedge i_clock);
        i_spi_boot_master <= 1'b0;
        cyc(4);
        `CHK(o_periph_pad_oe_n[1:0], 2'b11)
        done("peripheral side");
        final_report();
    end
endmodule
